// ### verilog/spi_eeprom_access_control.sv

`include "eeprom_defs.svh"

module prog_fifo #(
  parameter int WIDTH = 17,
  parameter int DEPTH = 16
) (
  input wire logic i_ref_clk,
  input wire logic i_reset,
  input wire logic i_in_valid,
  output logic o_in_ready,
  input wire logic [WIDTH-1:0] i_in_data,
  output logic o_out_valid,
  input wire logic i_out_ready,
  output logic [WIDTH-1:0] o_out_data
);
  // Depth must be a power of two so the pointers wrap naturally
  localparam int PW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [PW-1:0] wr_q;
  logic [PW-1:0] rd_q;
  logic [PW:0] cnt_q;
  logic push;
  logic pop;

  assign o_in_ready = (cnt_q != (PW+1)'(DEPTH));
  assign o_out_valid = (cnt_q != '0);
  assign o_out_data = mem_q[rd_q];
  assign push = i_in_valid & o_in_ready;
  assign pop = o_out_valid & i_out_ready;

  always_ff @(posedge i_ref_clk) begin
    if (push) begin
      mem_q[wr_q] <= i_in_data;
    end
  end

  always_ff @(posedge i_ref_clk or posedge i_reset) begin
    if (i_reset) begin
      wr_q <= '0;
      rd_q <= '0;
      cnt_q <= '0;
    end else begin
      if (push) begin
        wr_q <= PW'(wr_q + 1'b1);
      end
      if (pop) begin
        rd_q <= PW'(rd_q + 1'b1);
      end
      case ({push, pop})
        2'h2: cnt_q <= (PW+1)'(cnt_q + 1'b1);
        2'h1: cnt_q <= (PW+1)'(cnt_q - 1'b1);
        default: cnt_q <= cnt_q;
      endcase
    end
  end
endmodule : prog_fifo

module spi_eeprom_access_control #(
  parameter int ADDR_W = `ADDR_W_DEFAULT,
  parameter int WRITE_CYCLES = `SELF_TIMED_WRITE_CYCLES,
  parameter int FIFO_DEPTH = `PAGE_BYTES
) (
  input wire logic i_ref_clk,
  input wire logic i_reset,
  input wire logic i_sclk,
  input wire logic i_cs_n,
  input wire logic i_mosi,
  input wire logic i_hold_n,
  input wire logic i_wp_n,
  output logic o_miso,
  output logic o_miso_oe,
  output logic o_write_busy_flag,
  output logic o_write_enable_flag,
  output logic [1:0] o_protect_size
);
  localparam int MEM_DEPTH = 1 << ADDR_W;
  localparam logic [8:0] ADDR_MASK = 9'((1 << ADDR_W) - 1);
  localparam logic [31:0] LAST_TICK = 32'(WRITE_CYCLES - 1);

  eeprom_pkg::pins_t meta_q;
  eeprom_pkg::pins_t sync_q;
  eeprom_pkg::state_t state_q;
  eeprom_pkg::state_t cmd_next;
  eeprom_pkg::prog_word_t push_word;
  eeprom_pkg::prog_word_t pop_word;
  logic sclk_prev_q;
  logic cs_prev_q;
  logic armed_q;
  logic selected_q;
  logic hold_q;
  logic active;
  logic sclk_rise;
  logic sclk_fall;
  logic cs_fall;
  logic cs_rise;
  logic [2:0] bit_q;
  logic [7:0] sh_q;
  logic [7:0] new_byte;
  logic byte_done;
  logic cmd_ok;
  logic [2:0] op;
  logic wr_mode_q;
  logic a8_q;
  logic [8:0] addr_q;
  logic [7:0] pbuf_q [`PAGE_BYTES];
  logic [`PAGE_BYTES-1:0] pvalid_q;
  logic [8:4] page_q;
  logic wel_q;
  logic busy_q;
  logic [1:0] bp_q;
  logic [1:0] bp_new_q;
  logic sr_pend_q;
  logic [31:0] timer_q;
  logic [`PAGE_W:0] walk_q;
  logic [3:0] pace_q;
  logic wr_commit;
  logic sr_commit;
  logic push_valid;
  logic push_ready;
  logic walk_adv;
  logic pop_valid;
  logic pop_ready;
  logic prot;
  logic done;
  logic [7:0] mem_q [MEM_DEPTH];
  logic [7:0] status;
  logic [7:0] cur_byte;
  logic miso_q;
  logic oe_q;

  // Two flops on every pin before any logic looks at it
  always_ff @(posedge i_ref_clk or posedge i_reset) begin
    if (i_reset) begin
      meta_q <= `PINS_IDLE;
      sync_q <= `PINS_IDLE;
      sclk_prev_q <= 1'b0;
      cs_prev_q <= 1'b1;
    end else begin
      meta_q <= {i_sclk, i_cs_n, i_mosi, i_hold_n, i_wp_n};
      sync_q <= meta_q;
      sclk_prev_q <= sync_q.sclk;
      cs_prev_q <= sync_q.cs_n;
    end
  end

  assign active = selected_q & ~hold_q;
  assign sclk_rise = active & sync_q.sclk & ~sclk_prev_q;
  assign sclk_fall = active & ~sync_q.sclk & sclk_prev_q;
  assign cs_fall = armed_q & cs_prev_q & ~sync_q.cs_n;
  assign cs_rise = selected_q & sync_q.cs_n;
  assign new_byte = {sh_q[6:0], sync_q.mosi};
  assign byte_done = sclk_rise & (bit_q == 3'h7);
  assign op = new_byte[2:0];
  assign cmd_ok = byte_done & (state_q == eeprom_pkg::ST_CMD)
                & (new_byte[7:4] == `CMD_UPPER);

  // Select edges are armed by the first clock after reset, since the synchroniser resets select high
  always_ff @(posedge i_ref_clk or posedge i_reset) begin
    if (i_reset) begin
      armed_q <= 1'b0;
      selected_q <= 1'b0;
    end else begin
      if (sync_q.cs_n) begin
        armed_q <= 1'b1;
      end
      if (cs_rise) begin
        selected_q <= 1'b0;
      end else if (cs_fall) begin
        selected_q <= 1'b1;
      end
    end
  end

  // Hold starts and ends only while the serial clock is low
  always_ff @(posedge i_ref_clk or posedge i_reset) begin
    if (i_reset) begin
      hold_q <= 1'b0;
    end else if (!sync_q.hold_n && !sync_q.sclk && selected_q) begin
      hold_q <= 1'b1;
    end else if (sync_q.hold_n && !sync_q.sclk) begin
      hold_q <= 1'b0;
    end
  end

  always_ff @(posedge i_ref_clk or posedge i_reset) begin
    if (i_reset) begin
      bit_q <= 3'h0;
      sh_q <= 8'h00;
    end else if (cs_fall) begin
      bit_q <= 3'h0;
    end else if (sclk_rise) begin
      bit_q <= 3'(bit_q + 3'h1);
      sh_q <= new_byte;
    end
  end

  always_comb begin
    cmd_next = eeprom_pkg::ST_OFF;
    if (new_byte[7:4] == `CMD_UPPER) begin
      case (op)
        `OP_LATCH_EN: cmd_next = eeprom_pkg::ST_WAIT;
        `OP_LATCH_DIS: cmd_next = eeprom_pkg::ST_WAIT;
        `OP_STAT_RD: cmd_next = eeprom_pkg::ST_SR_RD;
        `OP_STAT_WR: cmd_next = busy_q ? eeprom_pkg::ST_OFF : eeprom_pkg::ST_SR_DATA;
        `OP_ARR_RD: cmd_next = busy_q ? eeprom_pkg::ST_OFF : eeprom_pkg::ST_ADDR;
        `OP_ARR_WR: begin
          if (busy_q || !wel_q) begin
            cmd_next = eeprom_pkg::ST_OFF;
          end else begin
            cmd_next = eeprom_pkg::ST_ADDR;
          end
        end
        default: cmd_next = eeprom_pkg::ST_OFF;
      endcase
    end
  end

  always_ff @(posedge i_ref_clk or posedge i_reset) begin
    if (i_reset) begin
      state_q <= eeprom_pkg::ST_IDLE;
    end else if (cs_rise) begin
      state_q <= eeprom_pkg::ST_IDLE;
    end else if (cs_fall) begin
      state_q <= eeprom_pkg::ST_CMD;
    end else if (sclk_rise) begin
      case (state_q)
        eeprom_pkg::ST_CMD: begin
          if (byte_done) begin
            state_q <= cmd_next;
          end
        end
        eeprom_pkg::ST_ADDR: begin
          if (byte_done) begin
            state_q <= wr_mode_q ? eeprom_pkg::ST_WDATA : eeprom_pkg::ST_RD;
          end
        end
        eeprom_pkg::ST_SR_DATA: begin
          if (byte_done) begin
            state_q <= eeprom_pkg::ST_SR_DONE;
          end
        end
        // A 17th clock spoils the status write
        eeprom_pkg::ST_SR_DONE: state_q <= eeprom_pkg::ST_OFF;
        default: state_q <= state_q;
      endcase
    end
  end

  always_ff @(posedge i_ref_clk or posedge i_reset) begin
    if (i_reset) begin
      wr_mode_q <= 1'b0;
      a8_q <= 1'b0;
      addr_q <= 9'h000;
    end else if (byte_done) begin
      if (cmd_ok) begin
        wr_mode_q <= (op == `OP_ARR_WR);
        a8_q <= new_byte[3];
      end
      case (state_q)
        eeprom_pkg::ST_ADDR: addr_q <= {a8_q, new_byte} & ADDR_MASK;
        eeprom_pkg::ST_RD: addr_q <= 9'(addr_q + 9'h001) & ADDR_MASK;
        eeprom_pkg::ST_WDATA: addr_q <= {addr_q[8:4], 4'(addr_q[3:0] + 4'h1)};
        default: addr_q <= addr_q;
      endcase
    end
  end

  // Page latch; loading and the commit walk never overlap in time
  always_ff @(posedge i_ref_clk or posedge i_reset) begin
    if (i_reset) begin
      page_q <= 5'h00;
      pvalid_q <= '0;
      for (int i = 0; i < `PAGE_BYTES; i++) begin
        pbuf_q[i] <= 8'h00;
      end
    end else if (byte_done && state_q == eeprom_pkg::ST_ADDR && wr_mode_q) begin
      // Page number is fixed for the whole frame; only the low nibble wraps
      page_q <= {a8_q, new_byte[7:4]};
      pvalid_q <= '0;
    end else if (byte_done && state_q == eeprom_pkg::ST_WDATA) begin
      pbuf_q[addr_q[3:0]] <= new_byte;
      pvalid_q[addr_q[3:0]] <= 1'b1;
    end else if (walk_adv) begin
      pvalid_q[walk_q[3:0]] <= 1'b0;
    end
  end

  // Commit only on a byte boundary with the latch still set
  assign wr_commit = cs_rise & (state_q == eeprom_pkg::ST_WDATA) & (bit_q == 3'h0)
                   & (|pvalid_q) & wel_q & sync_q.wp_n;
  assign sr_commit = cs_rise & (state_q == eeprom_pkg::ST_SR_DONE)
                   & wel_q & sync_q.wp_n;

  always_ff @(posedge i_ref_clk or posedge i_reset) begin
    if (i_reset) begin
      wel_q <= 1'b0;
    end else if (!sync_q.wp_n) begin
      wel_q <= 1'b0;
    end else if (cmd_ok && op == `OP_LATCH_EN) begin
      wel_q <= 1'b1;
    end else if ((cmd_ok && op == `OP_LATCH_DIS) || done) begin
      wel_q <= 1'b0;
    end
  end

  assign push_valid = busy_q & ~walk_q[`PAGE_W] & pvalid_q[walk_q[3:0]];
  assign walk_adv = busy_q & ~walk_q[`PAGE_W] & (~pvalid_q[walk_q[3:0]] | push_ready);
  assign push_word = '{addr: {page_q, walk_q[3:0]}, data: pbuf_q[walk_q[3:0]]};
  assign pop_ready = (pace_q == 4'h0);
  assign done = busy_q & (timer_q == LAST_TICK) & walk_q[`PAGE_W] & ~pop_valid;

  // Programming drains slower than the walk fills, so the FIFO can back up
  prog_fifo #(
    .WIDTH($bits(eeprom_pkg::prog_word_t)),
    .DEPTH(FIFO_DEPTH)
  ) u_prog_fifo (
    .i_ref_clk(i_ref_clk),
    .i_reset(i_reset),
    .i_in_valid(push_valid),
    .o_in_ready(push_ready),
    .i_in_data(push_word),
    .o_out_valid(pop_valid),
    .i_out_ready(pop_ready),
    .o_out_data(pop_word)
  );

  always_ff @(posedge i_ref_clk or posedge i_reset) begin
    if (i_reset) begin
      pace_q <= 4'h0;
    end else if (pace_q == 4'(`PROG_PACE - 4'h1)) begin
      pace_q <= 4'h0;
    end else begin
      pace_q <= 4'(pace_q + 4'h1);
    end
  end

  always_ff @(posedge i_ref_clk or posedge i_reset) begin
    if (i_reset) begin
      busy_q <= 1'b0;
      timer_q <= 32'h0;
      walk_q <= '0;
      sr_pend_q <= 1'b0;
      bp_new_q <= `BP_RESET;
      bp_q <= `BP_RESET;
    end else if (wr_commit || sr_commit) begin
      busy_q <= 1'b1;
      timer_q <= 32'h0;
      walk_q <= sr_commit ? (`PAGE_W+1)'(`PAGE_BYTES) : '0;
      sr_pend_q <= sr_commit;
      bp_new_q <= sh_q[`SR_BP_HI:`SR_BP_LO];
    end else if (busy_q) begin
      if (timer_q != LAST_TICK) begin
        timer_q <= 32'(timer_q + 32'h1);
      end
      if (walk_adv) begin
        walk_q <= (`PAGE_W+1)'(walk_q + 1'b1);
      end
      if (done) begin
        busy_q <= 1'b0;
        if (sr_pend_q) begin
          bp_q <= bp_new_q;
        end
      end
    end
  end

  always_comb begin
    case (bp_q)
      2'h1: prot = (pop_word.addr[ADDR_W-1 -: 2] == 2'h3);
      2'h2: prot = pop_word.addr[ADDR_W-1];
      2'h3: prot = 1'b1;
      default: prot = 1'b0;
    endcase
  end

  always_ff @(posedge i_ref_clk or posedge i_reset) begin
    if (i_reset) begin
      for (int i = 0; i < MEM_DEPTH; i++) begin
        mem_q[i] <= `ERASED_BYTE;
      end
    end else if (pop_valid && pop_ready && !prot) begin
      mem_q[pop_word.addr[ADDR_W-1:0]] <= pop_word.data;
    end
  end

  assign status = {`SR_ONES, bp_q, wel_q, busy_q};
  assign cur_byte = (state_q == eeprom_pkg::ST_RD) ? mem_q[addr_q[ADDR_W-1:0]] : status;

  always_ff @(posedge i_ref_clk or posedge i_reset) begin
    if (i_reset) begin
      miso_q <= 1'b0;
      oe_q <= 1'b0;
    end else begin
      oe_q <= active & ((state_q == eeprom_pkg::ST_RD) | (state_q == eeprom_pkg::ST_SR_RD));
      if (sclk_fall) begin
        miso_q <= cur_byte[3'h7 - bit_q];
      end
    end
  end

  assign o_miso = miso_q;
  assign o_miso_oe = oe_q;
  assign o_write_busy_flag = busy_q;
  assign o_write_enable_flag = wel_q;
  assign o_protect_size = bp_q;

  default clocking cb @(posedge i_ref_clk);
  endclocking
  default disable iff (i_reset);

  chk_commit_sets_busy: assert property ((wr_commit || sr_commit) |=> busy_q)
    else $error("busy not raised after commit");
  chk_done_clears_wel: assert property (done && !(cmd_ok && op == `OP_LATCH_EN) |=> !wel_q)
    else $error("write-enable survived completion");
  chk_wp_clears_wel: assert property (!sync_q.wp_n |=> !o_write_enable_flag)
    else $error("write-enable set while protected");
  chk_busy_needs_wel: assert property ($rose(busy_q) |-> $past(wel_q))
    else $error("write started without write-enable");
  chk_bp_frozen: assert property (busy_q && $past(busy_q) |-> $stable(bp_q))
    else $error("protect bits moved during write");
  chk_read_reject: assert property (cmd_ok && op == `OP_ARR_RD && busy_q
    |=> state_q == eeprom_pkg::ST_OFF)
    else $error("array read accepted while busy");
  chk_invalid_off: assert property (byte_done && state_q == eeprom_pkg::ST_CMD
    && new_byte[7:4] != `CMD_UPPER |=> state_q == eeprom_pkg::ST_OFF)
    else $error("undefined instruction not dropped");
  chk_busy_duration: assert property ($fell(busy_q) |-> $past(timer_q) == LAST_TICK)
    else $error("write ended before its time");
  chk_read_wrap: assert property (byte_done && state_q == eeprom_pkg::ST_RD
    && addr_q == ADDR_MASK |=> addr_q == 9'h000)
    else $error("read address did not wrap");
  chk_page_wrap: assert property (byte_done && state_q == eeprom_pkg::ST_WDATA
    && addr_q[3:0] == 4'hf |=> addr_q[3:0] == 4'h0 && $stable(addr_q[8:4]))
    else $error("page address left its page");
  chk_wait_holds: assert property (state_q == eeprom_pkg::ST_WAIT && !cs_rise
    |=> state_q == eeprom_pkg::ST_WAIT)
    else $error("wait state left without deselect");

endmodule : spi_eeprom_access_control

// ### verilog/eeprom_defs.svh
`ifndef EEPROM_DEFS_SVH
`define EEPROM_DEFS_SVH

// Instruction byte: upper nibble zero, bit 3 carries the ninth address bit
`define CMD_UPPER 4'h0
`define OP_LATCH_EN 3'h6
`define OP_LATCH_DIS 3'h4
`define OP_STAT_RD 3'h5
`define OP_STAT_WR 3'h1
`define OP_ARR_RD 3'h3
`define OP_ARR_WR 3'h2

// Status byte layout
`define SR_ONES 4'hf
`define SR_BP_HI 3
`define SR_BP_LO 2
`define BP_RESET 2'h0

// Array and page geometry
`define ADDR_W_MAX 9
`define ADDR_W_DEFAULT 9
`define PAGE_BYTES 16
`define PAGE_W 4
`define ERASED_BYTE 8'hff

// Timing
`define SELF_TIMED_WRITE_TIME_NS 10000000
`define REF_PERIOD_NS 10
`define SELF_TIMED_WRITE_CYCLES (`SELF_TIMED_WRITE_TIME_NS / `REF_PERIOD_NS)
`define PROG_PACE 4'h4

// Pin idle levels: sclk, cs_n, mosi, hold_n, wp_n
`define PINS_IDLE 5'h0b

`endif

// ### verilog/eeprom_pkg.sv
package eeprom_pkg;

  typedef enum logic [9:0] {
    ST_IDLE = 10'h001,
    ST_CMD = 10'h002,
    ST_ADDR = 10'h004,
    ST_RD = 10'h008,
    ST_SR_RD = 10'h010,
    ST_WDATA = 10'h020,
    ST_SR_DATA = 10'h040,
    ST_SR_DONE = 10'h080,
    ST_WAIT = 10'h100,
    ST_OFF = 10'h200
  } state_t;

  typedef struct packed {
    logic sclk;
    logic cs_n;
    logic mosi;
    logic hold_n;
    logic wp_n;
  } pins_t;

  typedef struct packed {
    logic [8:0] addr;
    logic [7:0] data;
  } prog_word_t;

endpackage : eeprom_pkg

// ### test/spi_master_model.sv
module spi_master_model (
  input wire logic i_ref_clk,
  input wire logic i_miso_pin,
  output logic o_sclk,
  output logic o_cs_n,
  output logic o_mosi,
  output logic o_rx_valid,
  output logic [7:0] o_rx_byte
);
  timeunit 1ns;
  timeprecision 100ps;

  // Half of the 80 ns link period, in reference cycles
  localparam int HALF = 4;

  initial begin
    o_sclk = 1'b0;
    o_cs_n = 1'b1;
    o_mosi = 1'b0;
    o_rx_valid = 1'b0;
    o_rx_byte = 8'h00;
  end

  task automatic idle(input int n);
    repeat (n) @(negedge i_ref_clk);
  endtask : idle

  task automatic select();
    idle(1);
    o_cs_n = 1'b0;
    idle(HALF);
  endtask : select

  // Mode 0: bit set while low, both sides sample on the rise
  task automatic shift(input logic [7:0] tx, input int n, input bit report,
                       output logic [7:0] rx);
    rx = 8'h00;
    for (int b = 7; b > 7 - n; b--) begin
      o_mosi = tx[b];
      idle(HALF);
      rx = {rx[6:0], i_miso_pin};
      o_sclk = 1'b1;
      idle(HALF);
      o_sclk = 1'b0;
    end
    if (report) begin
      o_rx_byte = rx;
      o_rx_valid = 1'b1;
      idle(1);
      o_rx_valid = 1'b0;
    end
  endtask : shift

  // Clock parks low; a released data line shows the inverse of its last bit
  task automatic deselect();
    idle(HALF);
    o_cs_n = 1'b1;
    o_mosi = ~o_mosi;
    idle(8);
  endtask : deselect
endmodule : spi_master_model

// ### test/spi_eeprom_access_control_tb.sv
module spi_eeprom_access_control_tb;
  timeunit 1ns;
  timeprecision 100ps;

  // Short write time keeps the run small; must exceed the buffer drain
  localparam int WRITE_CYCLES = 200;
  localparam int POLL_MAX = 40;

  logic ref_clk, reset, wp_n, hold_n;
  logic sclk, cs_n, mosi, miso, miso_oe, busy, write_enable_flag;
  logic [1:0] protect;
  logic rx_valid, saw_oe, miso_last, miso_pin;
  logic [7:0] rx_byte, last_rx;
  logic [7:0] mem [512];
  logic [7:0] exp_q [$];
  logic [7:0] bad_ops [3] = '{8'h07, 8'h08, 8'h15};
  logic [31:0] seed = 32'h76de;
  int bad_count, n_compared;

  spi_eeprom_access_control #(
    .ADDR_W(9),
    .WRITE_CYCLES(WRITE_CYCLES),
    .FIFO_DEPTH(16)
  ) i_spi_eeprom_access_control (
    .i_ref_clk(ref_clk),
    .i_reset(reset),
    .i_sclk(sclk),
    .i_cs_n(cs_n),
    .i_mosi(mosi),
    .i_hold_n(hold_n),
    .i_wp_n(wp_n),
    .o_miso(miso),
    .o_miso_oe(miso_oe),
    .o_write_busy_flag(busy),
    .o_write_enable_flag(write_enable_flag),
    .o_protect_size(protect)
  );

  spi_master_model i_spi_master_model (
    .i_ref_clk(ref_clk),
    .i_miso_pin(miso_pin),
    .o_sclk(sclk),
    .o_cs_n(cs_n),
    .o_mosi(mosi),
    .o_rx_valid(rx_valid),
    .o_rx_byte(rx_byte)
  );

  // Undriven output floats: show the inverse of the last driven bit
  assign miso_pin = (miso_oe === 1'b1) ? miso : ~miso_last;

  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  function automatic logic [7:0] rnd8();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[7:0];
  endfunction : rnd8

  task automatic fail(input string msg);
    bad_count++;
    $display("[ERR] %0t %s", $time, msg);
  endtask : fail

  task automatic chk(input logic [7:0] got, input logic [7:0] e, input string what);
    n_compared++;
    if (got !== e) begin
      bad_count++;
      $display("[ERR] %0t %s: got %h expected %h", $time, what, got, e);
    end
  endtask : chk

  task automatic chk_flags(input logic [3:0] e, input string what);
    chk({4'h0, protect, write_enable_flag, busy}, {4'h0, e}, what);
  endtask : chk_flags

  task automatic results();
    $display("compared %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : results

  task automatic sel();
    i_spi_master_model.select();
  endtask : sel

  task automatic desel();
    i_spi_master_model.deselect();
  endtask : desel

  task automatic wt(input int n);
    i_spi_master_model.idle(n);
  endtask : wt

  task automatic tx(input logic [7:0] b, input int n, input bit rep);
    i_spi_master_model.shift(b, n, rep, last_rx);
  endtask : tx

  task automatic cmd1(input logic [7:0] op);
    sel();
    tx(op, 8, 1'b0);
    desel();
  endtask : cmd1

  task automatic rd_status(input logic [7:0] e, input bit rep);
    if (rep) exp_q.push_back(e);
    sel();
    tx(8'h05, 8, 1'b0);
    tx(8'h00, 8, rep);
    desel();
  endtask : rd_status

  task automatic poll_idle();
    int n;
    n = 0;
    do begin
      rd_status(8'h00, 1'b0);
      n++;
    end while (last_rx[0] !== 1'b0 && n < POLL_MAX);
    if (n >= POLL_MAX) fail("busy flag never cleared");
  endtask : poll_idle

  // Model memory follows the in-page address wrap of the write path
  task automatic wr_array(input logic [8:0] a, input int nb, input int extra, input bit prog);
    logic [8:0] p;
    logic [7:0] d;
    p = a;
    sel();
    tx({4'h0, a[8], 3'h2}, 8, 1'b0);
    tx(a[7:0], 8, 1'b0);
    for (int k = 0; k < nb; k++) begin
      d = rnd8();
      tx(d, 8, 1'b0);
      if (prog) mem[p] = d;
      p = {p[8:4], p[3:0] + 4'h1};
    end
    if (extra > 0) tx(8'ha5, extra, 1'b0);
    desel();
  endtask : wr_array

  task automatic rd_array(input logic [8:0] a, input int nb);
    for (int k = 0; k < nb; k++) exp_q.push_back(mem[a + 9'(k)]);
    sel();
    tx({4'h0, a[8], 3'h3}, 8, 1'b0);
    tx(a[7:0], 8, 1'b0);
    for (int k = 0; k < nb; k++) tx(8'h00, 8, 1'b1);
    desel();
  endtask : rd_array

  always @(posedge ref_clk) begin
    if (miso_oe === 1'b1) begin
      saw_oe = 1'b1;
      miso_last <= miso;
    end
    if (rx_valid === 1'b1) begin
      if (exp_q.size() == 0) begin
        fail("read byte with no expectation");
      end else begin
        chk(rx_byte, exp_q.pop_front(), "read byte");
      end
    end
  end

  initial begin
    #400000;
    fail("watchdog expired");
    results();
  end

  initial begin
    reset = 1'b1;
    wp_n = 1'b1;
    hold_n = 1'b1;
    miso_last = 1'b0;
    saw_oe = 1'b0;
    foreach (mem[i]) mem[i] = 8'hff;
    repeat (5) @(negedge ref_clk);
    reset = 1'b0;
    wt(6);
    chk_flags(4'h0, "flags after reset");
    chk({7'h0, miso_oe}, 8'h00, "output enable after reset");
    rd_status(8'hf0, 1'b1);
    wr_array(9'h020, 1, 0, 1'b0);
    chk_flags(4'h0, "write without latch");
    rd_array(9'h020, 1);
    cmd1(8'h0e);
    chk_flags(4'h2, "latch enable");
    cmd1(8'h0c);
    chk_flags(4'h0, "latch disable");
    cmd1(8'h06);
    wp_n = 1'b0;
    wt(6);
    chk_flags(4'h0, "write protect low");
    wp_n = 1'b1;
    foreach (bad_ops[i]) begin
      saw_oe = 1'b0;
      sel();
      tx(bad_ops[i], 8, 1'b0);
      tx(8'h00, 8, 1'b0);
      desel();
      chk({7'h0, saw_oe}, 8'h00, "output after bad code");
    end
    cmd1(8'h06);
    sel();
    tx(8'h01, 8, 1'b0);
    tx(8'h04, 8, 1'b0);
    tx(8'h04, 1, 1'b0);
    desel();
    chk_flags(4'h2, "status write with 17th clock");
    sel();
    tx(8'h01, 8, 1'b0);
    tx(8'h04, 8, 1'b0);
    desel();
    chk({7'h0, busy}, 8'h01, "busy after status write");
    rd_status(8'hf3, 1'b1);
    poll_idle();
    rd_status(8'hf4, 1'b1);
    chk_flags(4'h4, "after status write");
    cmd1(8'h06);
    wr_array(9'h00e, 18, 0, 1'b1);
    chk({7'h0, busy}, 8'h01, "busy after page write");
    saw_oe = 1'b0;
    sel();
    tx(8'h03, 8, 1'b0);
    tx(8'h00, 8, 1'b0);
    tx(8'h00, 8, 1'b0);
    desel();
    chk({7'h0, saw_oe}, 8'h00, "read during write cycle");
    poll_idle();
    chk_flags(4'h4, "after page write");
    rd_array(9'h000, 16);
    cmd1(8'h06);
    wr_array(9'h105, 1, 3, 1'b0);
    chk_flags(4'h6, "write off byte boundary");
    wr_array(9'h105, 1, 0, 1'b1);
    poll_idle();
    cmd1(8'h06);
    wr_array(9'h1c0, 1, 0, 1'b0);
    poll_idle();
    rd_array(9'h1c0, 1);
    rd_array(9'h104, 3);
    rd_array(9'h1fe, 5);
    exp_q.push_back(8'hf4);
    sel();
    tx(8'h05, 8, 1'b0);
    hold_n = 1'b0;
    wt(8);
    chk({7'h0, miso_oe}, 8'h00, "output during hold");
    hold_n = 1'b1;
    wt(8);
    tx(8'h00, 8, 1'b1);
    desel();
    chk(8'(exp_q.size()), 8'h00, "reads left unanswered");
    results();
  end
endmodule : spi_eeprom_access_control_tb
